// File: inc/event_unit_pkg.sv
// constants, field layouts and carrier types of the pressure event and interrupt unit
// ****************************************************************************
// ****************************************************************************
package event_unit_pkg;

    // ************************************************************************
    // register offsets
    // ************************************************************************
    localparam logic [7:0] ADDR_EVENT_FLAGS    = 8'hc1;
    localparam logic [7:0] ADDR_EVENT_SUPPRESS = 8'hc2;
    localparam logic [7:0] ADDR_QUEUE_SETUP    = 8'hc3;
    localparam logic [7:0] ADDR_LEVEL_LOW      = 8'hc7;
    localparam logic [7:0] ADDR_LEVEL_HIGH     = 8'hc8;
    localparam logic [7:0] ADDR_STEP_LOW       = 8'hc9;
    localparam logic [7:0] ADDR_STEP_HIGH      = 8'hca;

    // ************************************************************************
    // field positions
    // ************************************************************************
    localparam int BIT_FULL_PUSH   = 0;
    localparam int BIT_EMPTY_FETCH = 1;
    localparam int BIT_UPPER_MARK  = 2;
    localparam int BIT_LOWER_MARK  = 3;
    localparam int BIT_LEVEL       = 5;
    localparam int BIT_STEP        = 6;
    localparam int UPPER_MARK_MSB  = 7;
    localparam int UPPER_MARK_LSB  = 4;
    localparam int LOWER_MARK_MSB  = 3;
    localparam int LOWER_MARK_LSB  = 0;
    localparam logic [7:0] FLAG_BITS_USED = 8'h6f;

    // ************************************************************************
    // reset values
    // ************************************************************************
    localparam logic [7:0] FLAGS_RST    = 8'h00;
    localparam logic [7:0] SUPPRESS_RST = 8'h6f;
    localparam logic [7:0] QUEUE_RST    = 8'h00;
    localparam logic [7:0] LIMIT_RST    = 8'h00;

    // ************************************************************************
    // widths
    // ************************************************************************
    localparam int PRESS_W     = 20;
    localparam int LIMIT_W     = 16;
    localparam int CMP_LSB     = PRESS_W - LIMIT_W;
    localparam int LEVEL_W     = 5;
    localparam logic [LEVEL_W-1:0] QUEUE_DEPTH = 5'h10;
    localparam logic [LEVEL_W-1:0] QUEUE_EMPTY = 5'h00;

    // ************************************************************************
    // carriers
    // ************************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic               valid;
        logic [PRESS_W-1:0] value;
    } press_sample_t;

    typedef struct packed {
        logic               push;
        logic               fetch;
        logic [LEVEL_W-1:0] level;
    } queue_event_t;

    typedef enum logic {
        WAIT_FIRST = 1'b0,
        TRACKING   = 1'b1
    } sample_state_t;

endpackage : event_unit_pkg

// File: core/pressure_event_interrupt_unit.sv
// pressure threshold, fill mark and queue error events with latched flags and open-drain pin
`timescale 1ns/1ns
module pressure_event_interrupt_unit (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         sys_rst_in,
    // serial register interface, byte wide
    input  wire event_unit_pkg::reg_req_t     reg_req_in,
    output logic [7:0]                        reg_rdata_out,
    // new pressure results
    input  wire event_unit_pkg::press_sample_t press_in,
    // measurement queue activity
    input  wire event_unit_pkg::queue_event_t queue_in,
    // open-drain interrupt pin
    input  wire logic                         int_pin_in,
    output logic                              int_pin_out,
    output logic                              int_pin_oe_out
);

    // ************************************************************************
    // functions
    // ************************************************************************
    function automatic logic reg_hit(input event_unit_pkg::reg_req_t req,
                                     input logic [7:0] addr);
        reg_hit = req.wr && (req.addr == addr);
    endfunction : reg_hit

    function automatic logic at_or_above(input logic [event_unit_pkg::LIMIT_W-1:0] val,
                                         input logic [event_unit_pkg::LIMIT_W-1:0] lim);
        at_or_above = $signed(val) >= $signed(lim);
    endfunction : at_or_above

    // ************************************************************************
    // register state
    // ************************************************************************
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] suppress_q;
    logic [7:0] suppress_d;
    logic [7:0] queue_setup_q;
    logic [7:0] queue_setup_d;
    logic [7:0] level_low_q;
    logic [7:0] level_low_d;
    logic [7:0] level_high_q;
    logic [7:0] level_high_d;
    logic [7:0] step_low_q;
    logic [7:0] step_low_d;
    logic [7:0] step_high_q;
    logic [7:0] step_high_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // ************************************************************************
    // event state
    // ************************************************************************
    event_unit_pkg::sample_state_t         sample_state_q;
    event_unit_pkg::sample_state_t         sample_state_d;
    logic [event_unit_pkg::LIMIT_W-1:0]    prev_press_q;
    logic [event_unit_pkg::LIMIT_W-1:0]    prev_press_d;
    logic [event_unit_pkg::LEVEL_W-1:0]    prev_level_q;
    logic [event_unit_pkg::LEVEL_W-1:0]    prev_level_d;
    logic                                  int_drive_q;
    logic                                  int_drive_d;
    logic                                  int_low_q;

    // ************************************************************************
    // event detection
    // ************************************************************************
    logic [event_unit_pkg::LIMIT_W-1:0]    level_limit;
    logic [event_unit_pkg::LIMIT_W-1:0]    step_limit;
    logic [event_unit_pkg::LIMIT_W-1:0]    cur_press;
    logic [event_unit_pkg::LIMIT_W:0]      step_diff;
    logic [event_unit_pkg::LIMIT_W:0]      step_mag;
    logic [event_unit_pkg::LEVEL_W-1:0]    upper_mark;
    logic [event_unit_pkg::LEVEL_W-1:0]    lower_mark;
    logic [7:0]                            events;

    always_comb begin
        level_limit = {level_high_q, level_low_q};
        step_limit  = {step_high_q, step_low_q};
        // only the upper 16 bits of the result meet the 16-bit limits
        cur_press   = press_in.value[event_unit_pkg::PRESS_W-1:event_unit_pkg::CMP_LSB];
        step_diff   = {cur_press[event_unit_pkg::LIMIT_W-1], cur_press}
                    - {prev_press_q[event_unit_pkg::LIMIT_W-1], prev_press_q};
        step_mag    = step_diff[event_unit_pkg::LIMIT_W] ? (~step_diff + 17'h00001) : step_diff;
        upper_mark  = {1'b0, queue_setup_q[event_unit_pkg::UPPER_MARK_MSB:
                                           event_unit_pkg::UPPER_MARK_LSB]};
        lower_mark  = {1'b0, queue_setup_q[event_unit_pkg::LOWER_MARK_MSB:
                                           event_unit_pkg::LOWER_MARK_LSB]};
        events = 8'h00;
        // a crossing either way raises the one level flag
        events[event_unit_pkg::BIT_LEVEL] = press_in.valid
            && (sample_state_q == event_unit_pkg::TRACKING)
            && (at_or_above(cur_press, level_limit)
                != at_or_above(prev_press_q, level_limit));
        // a step is judged on its magnitude, so rises and falls count alike
        events[event_unit_pkg::BIT_STEP] = press_in.valid
            && (sample_state_q == event_unit_pkg::TRACKING)
            && (step_mag > {1'b0, step_limit});
        // a mark counts once when the level arrives at it, not while it stays
        events[event_unit_pkg::BIT_UPPER_MARK] = (queue_in.level == upper_mark)
            && (prev_level_q != upper_mark);
        events[event_unit_pkg::BIT_LOWER_MARK] = (queue_in.level == lower_mark)
            && (prev_level_q != lower_mark);
        events[event_unit_pkg::BIT_FULL_PUSH] = queue_in.push
            && (queue_in.level == event_unit_pkg::QUEUE_DEPTH);
        events[event_unit_pkg::BIT_EMPTY_FETCH] = queue_in.fetch
            && (queue_in.level == event_unit_pkg::QUEUE_EMPTY);
    end

    // ************************************************************************
    // sample tracking
    // ************************************************************************
    always_comb begin
        sample_state_d = sample_state_q;
        // history keeps only the compared upper bits of each result
        prev_press_d   = prev_press_q;
        prev_level_d   = queue_in.level;
        case (sample_state_q)
            event_unit_pkg::WAIT_FIRST: begin
                if (press_in.valid) begin
                    sample_state_d = event_unit_pkg::TRACKING;
                    prev_press_d   = cur_press;
                end
            end
            event_unit_pkg::TRACKING: begin
                if (press_in.valid) begin
                    prev_press_d = cur_press;
                end
            end
            default: begin
                sample_state_d = event_unit_pkg::WAIT_FIRST;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sample_state_q <= event_unit_pkg::WAIT_FIRST;
            prev_press_q   <= '0;
            prev_level_q   <= event_unit_pkg::QUEUE_EMPTY;
        end else begin
            sample_state_q <= sample_state_d;
            prev_press_q   <= prev_press_d;
            prev_level_q   <= prev_level_d;
        end
    end

    // ************************************************************************
    // latched flags
    // ************************************************************************
    logic flags_wr;

    assign flags_wr = reg_hit(reg_req_in, event_unit_pkg::ADDR_EVENT_FLAGS);

    // a new event in the clearing cycle wins, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            always_comb begin
                if (!event_unit_pkg::FLAG_BITS_USED[gi]) begin
                    flags_d[gi] = 1'b0;
                end else if (events[gi]) begin
                    flags_d[gi] = 1'b1;
                end else if (flags_wr && reg_req_in.wdata[gi]) begin
                    flags_d[gi] = 1'b0;
                end else begin
                    flags_d[gi] = flags_q[gi];
                end
            end
        end
    endgenerate

    // ************************************************************************
    // write decode
    // ************************************************************************
    // one strobe per register keeps the address compare in one place
    logic wr_suppress;
    logic wr_queue_setup;
    logic wr_level_low;
    logic wr_level_high;
    logic wr_step_low;
    logic wr_step_high;

    assign wr_suppress    = reg_hit(reg_req_in, event_unit_pkg::ADDR_EVENT_SUPPRESS);
    assign wr_queue_setup = reg_hit(reg_req_in, event_unit_pkg::ADDR_QUEUE_SETUP);
    assign wr_level_low   = reg_hit(reg_req_in, event_unit_pkg::ADDR_LEVEL_LOW);
    assign wr_level_high  = reg_hit(reg_req_in, event_unit_pkg::ADDR_LEVEL_HIGH);
    assign wr_step_low    = reg_hit(reg_req_in, event_unit_pkg::ADDR_STEP_LOW);
    assign wr_step_high   = reg_hit(reg_req_in, event_unit_pkg::ADDR_STEP_HIGH);

    // ************************************************************************
    // configuration registers
    // ************************************************************************
    // limit bytes are live as soon as written; a host updating both halves
    // may see one compare against a mixed limit
    always_comb begin
        suppress_d    = suppress_q;
        queue_setup_d = queue_setup_q;
        level_low_d   = level_low_q;
        level_high_d  = level_high_q;
        step_low_d    = step_low_q;
        step_high_d   = step_high_q;
        if (wr_suppress) begin
            suppress_d = reg_req_in.wdata & event_unit_pkg::FLAG_BITS_USED;
        end
        if (wr_queue_setup) begin
            queue_setup_d = reg_req_in.wdata;
        end
        if (wr_level_low) begin
            level_low_d = reg_req_in.wdata;
        end
        if (wr_level_high) begin
            level_high_d = reg_req_in.wdata;
        end
        if (wr_step_low) begin
            step_low_d = reg_req_in.wdata;
        end
        if (wr_step_high) begin
            step_high_d = reg_req_in.wdata;
        end
    end

    // ************************************************************************
    // register read
    // ************************************************************************
    // read data holds between reads so a slow host can still pick it up
    always_comb begin
        rdata_d = rdata_q;
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                event_unit_pkg::ADDR_EVENT_FLAGS:    rdata_d = flags_q;
                event_unit_pkg::ADDR_EVENT_SUPPRESS: rdata_d = suppress_q;
                event_unit_pkg::ADDR_QUEUE_SETUP:    rdata_d = queue_setup_q;
                event_unit_pkg::ADDR_LEVEL_LOW:      rdata_d = level_low_q;
                event_unit_pkg::ADDR_LEVEL_HIGH:     rdata_d = level_high_q;
                event_unit_pkg::ADDR_STEP_LOW:       rdata_d = step_low_q;
                event_unit_pkg::ADDR_STEP_HIGH:      rdata_d = step_high_q;
                default:                             rdata_d = 8'h00;
            endcase
        end
    end

    // ************************************************************************
    // interrupt pin
    // ************************************************************************
    always_comb begin
        // blocked sources still latch, they just stay off the pin
        int_drive_d = |(flags_d & ~suppress_d & event_unit_pkg::FLAG_BITS_USED);
    end

    // ************************************************************************
    // registers
    // ************************************************************************
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flags_q <= event_unit_pkg::FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            suppress_q    <= event_unit_pkg::SUPPRESS_RST;
            queue_setup_q <= event_unit_pkg::QUEUE_RST;
            level_low_q   <= event_unit_pkg::LIMIT_RST;
            level_high_q  <= event_unit_pkg::LIMIT_RST;
            step_low_q    <= event_unit_pkg::LIMIT_RST;
            step_high_q   <= event_unit_pkg::LIMIT_RST;
        end else begin
            suppress_q    <= suppress_d;
            queue_setup_q <= queue_setup_d;
            level_low_q   <= level_low_d;
            level_high_q  <= level_high_d;
            step_low_q    <= step_low_d;
            step_high_q   <= step_high_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // the level register never leaves zero; only the enable carries the interrupt
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            int_drive_q <= 1'b0;
            int_low_q   <= 1'b0;
        end else begin
            int_drive_q <= int_drive_d;
            int_low_q   <= 1'b0;
        end
    end

    // the pin level is only ever zero; the enable alone signals the interrupt
    assign int_pin_out    = int_low_q;
    assign int_pin_oe_out = int_drive_q;
    assign reg_rdata_out  = rdata_q;

    // pin readback is unused; it exists so the wire stays three-signal at the port
    logic unused_pin;
    assign unused_pin = int_pin_in;

endmodule : pressure_event_interrupt_unit

// File: test/pressure_event_interrupt_unit_properties.sv
// port checker for the pressure event and interrupt unit
`timescale 1ns/1ns
module pressure_event_interrupt_unit_properties (
    // clock and reset
    input wire logic                          clk_in,
    input wire logic                          sys_rst_in,
    // watched ports
    input wire event_unit_pkg::reg_req_t      reg_req_in,
    input wire logic [7:0]                    reg_rdata_out,
    input wire event_unit_pkg::press_sample_t press_in,
    input wire event_unit_pkg::queue_event_t  queue_in,
    input wire logic                          int_pin_out,
    input wire logic                          int_pin_oe_out
);
    // ************************************************************************
    // shadow of the block register and of event causes
    // ************************************************************************
    logic [7:0] blk_q, blk_d;
    logic       cause_q, cause_d;
    logic [4:0] lvl_q;
    wire wr_c2  = reg_req_in.wr && reg_req_in.addr == event_unit_pkg::ADDR_EVENT_SUPPRESS;
    wire wr_clr = wr_c2 || (reg_req_in.wr && reg_req_in.addr == event_unit_pkg::ADDR_EVENT_FLAGS);
    wire all_blk = (blk_q & 8'h6f) == 8'h6f;
    wire rd_c1  = reg_req_in.rd && reg_req_in.addr == event_unit_pkg::ADDR_EVENT_FLAGS;
    wire rd_c2  = reg_req_in.rd && reg_req_in.addr == event_unit_pkg::ADDR_EVENT_SUPPRESS;
    always_comb begin
        blk_d   = wr_c2 ? reg_req_in.wdata : blk_q;
        // over-permissive on purpose: any input activity may raise the pin
        cause_d = press_in.valid | queue_in.push | queue_in.fetch | wr_c2
                | (queue_in.level != lvl_q);
    end
    always_ff @(posedge clk_in) begin
        blk_q   <= sys_rst_in ? event_unit_pkg::SUPPRESS_RST : blk_d;
        cause_q <= sys_rst_in ? 1'b0 : cause_d;
        lvl_q   <= queue_in.level;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ************************************************************************
    // properties
    // ************************************************************************
    property p_pin_low; int_pin_out == 1'b0; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin driven high");
    property p_oe_hold; int_pin_oe_out && !wr_clr && !$past(wr_clr) |=> int_pin_oe_out; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin released uncleared");
    property p_oe_cause; $rose(int_pin_oe_out) |-> cause_q || $past(wr_c2, 2); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin low without cause");
    property p_full_push;
        queue_in.push && queue_in.level == 5'h10 && !blk_q[0] && !wr_c2 && !$past(wr_c2)
            |=> int_pin_oe_out;
    endproperty
    a_full_push: assert property (p_full_push) else $error("push when full missed");
    property p_empty_fetch;
        queue_in.fetch && queue_in.level == 5'h00 && !blk_q[1] && !wr_c2 && !$past(wr_c2)
            |=> int_pin_oe_out;
    endproperty
    a_empty_fetch: assert property (p_empty_fetch) else $error("empty fetch missed");
    property p_all_blocked; all_blk [*3] |-> !int_pin_oe_out; endproperty
    a_all_blocked: assert property (p_all_blocked) else $error("blocked pin low");
    property p_rd_flags; rd_c1 |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[4] == 1'b0; endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("reserved flag bit set");
    property p_rd_block; rd_c2 |=> reg_rdata_out == ($past(blk_q) & 8'h6f); endproperty
    a_rd_block: assert property (p_rd_block) else $error("block reg read wrong");
    property p_rd_hold; !reg_req_in.rd |=> $stable(reg_rdata_out); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : pressure_event_interrupt_unit_properties

bind pressure_event_interrupt_unit pressure_event_interrupt_unit_properties u_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .press_in(press_in), .queue_in(queue_in),
    .int_pin_out(int_pin_out), .int_pin_oe_out(int_pin_oe_out));

// File: test/host_model.sv
// host model: byte register accesses and the pulled-up interrupt line
`timescale 1ns/1ns
module host_model (
    // clock and device side
    input  wire logic                     clk_in,
    input  wire logic [7:0]               rdata_in,
    input  wire logic                     pin_oe_in,
    // requests and resolved line
    output event_unit_pkg::reg_req_t      req_out,
    output logic                          line_out
);
    // released line rests high through the pull-up
    assign line_out = pin_oe_in ? 1'b0 : 1'b1;
    initial req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_in);
        req_out.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_in);
        req_out.rd = 1'b0;
        d = rdata_in;
    endtask : rd
endmodule : host_model

// File: test/pressure_event_interrupt_unit_tb_top.sv
// self-checking bench for the pressure event and interrupt unit
`timescale 1ns/1ns
module pressure_event_interrupt_unit_tb_top;
    // ************************************************************************
    // signals and instances
    // ************************************************************************
    logic                          clk_in = 1'b0;
    logic                          sys_rst_in = 1'b1;
    event_unit_pkg::reg_req_t      req;
    event_unit_pkg::press_sample_t press = '0;
    event_unit_pkg::queue_event_t  queue = '0;
    logic [7:0]                    rdata;
    logic                          pin_out, oe, line;
    int                            err_count = 0;
    int                            checks_done = 0;
    always #20 clk_in = ~clk_in;
    pressure_event_interrupt_unit dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_req_in(req), .reg_rdata_out(rdata), .press_in(press), .queue_in(queue),
        .int_pin_in(line), .int_pin_out(pin_out), .int_pin_oe_out(oe));
    host_model host (.clk_in(clk_in), .rdata_in(rdata), .pin_oe_in(oe), .req_out(req),
        .line_out(line));
    // ************************************************************************
    // shared tasks
    // ************************************************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", nm, e, s);
            err_count++;
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("reg_%h", a), e, d);
    endtask : rdc
    // read flags and line, clear by writing ones, line must return high
    task automatic settle(input logic [7:0] f, input logic p);
        rdc(8'hc1, f);
        chk("line", {7'h0, p}, {7'h0, line});
        chk("pin_level", 8'h00, {7'h0, pin_out});
        host.wr(8'hc1, f);
        repeat (3) @(negedge clk_in);
        chk("line_clr", 8'h01, {7'h0, line});
    endtask : settle
    task automatic qev(input logic u, input logic g, input logic [4:0] l, input logic [7:0] f,
                       input logic p);
        @(negedge clk_in);
        queue = '{push: u, fetch: g, level: l};
        @(negedge clk_in);
        queue.push = 1'b0;
        queue.fetch = 1'b0;
        settle(f, p);
    endtask : qev
    task automatic pev(input logic [15:0] v, input logic [7:0] f);
        @(negedge clk_in);
        press = '{valid: 1'b1, value: {v, 4'h0}};
        @(negedge clk_in);
        press.valid = 1'b0;
        settle(f, f == 8'h00);
    endtask : pev
    // ************************************************************************
    // scenarios
    // ************************************************************************
    task automatic t_regs;
        logic [7:0] ra[8] = '{8'hc1, 8'hc2, 8'hc3, 8'hc7, 8'hc8, 8'hc9, 8'hca, 8'hc4};
        logic [7:0] re[8] = '{8'h00, 8'h6f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        foreach (ra[i]) rdc(ra[i], re[i]);
        host.wr(8'hc2, 8'hff);
        rdc(8'hc2, 8'h6f);
        host.wr(8'hc3, 8'ha5);
        rdc(8'hc3, 8'ha5);
        host.wr(8'hc8, 8'h12);
        rdc(8'hc8, 8'h12);
        host.wr(8'hc1, 8'hff);
        rdc(8'hc1, 8'h00);
    endtask : t_regs
    task automatic t_queue;
        host.wr(8'hc3, 8'h52);
        host.wr(8'hc2, 8'h00);
        qev(1'b1, 1'b0, 5'h10, 8'h01, 1'b0);
        qev(1'b0, 1'b1, 5'h00, 8'h02, 1'b0);
        qev(1'b0, 1'b0, 5'h05, 8'h04, 1'b0);
        qev(1'b0, 1'b0, 5'h02, 8'h08, 1'b0);
        qev(1'b1, 1'b0, 5'h0f, 8'h00, 1'b1);
        host.wr(8'hc2, 8'h01);
        qev(1'b1, 1'b0, 5'h10, 8'h01, 1'b1);
    endtask : t_queue
    task automatic t_press;
        host.wr(8'hc2, 8'h00);
        host.wr(8'hc7, 8'h10);
        host.wr(8'hc8, 8'h01);
        host.wr(8'hc9, 8'h80);
        host.wr(8'hca, 8'h00);
        pev(16'h0200, 8'h00);
        pev(16'h0210, 8'h00);
        pev(16'h00f0, 8'h60);
        pev(16'h0110, 8'h20);
        pev(16'h0190, 8'h00);
        pev(16'h0211, 8'h40);
        pev(16'hfff0, 8'h60);
    endtask : t_press
    // ************************************************************************
    // run control
    // ************************************************************************
    task automatic final_report;
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_regs();
        t_queue();
        t_press();
        final_report();
    end
endmodule : pressure_event_interrupt_unit_tb_top
